// ---- common/rap_pkg.sv ----
// Purpose: shared constants, types and helpers for the read/auto-precharge
//          link between the memory device end and the controller end
// Assumes: one clock at 40 MHz; times held in picoseconds
// Notes:   timing defaults are plain values, override per speed grade
package rap_pkg;
  localparam int unsigned CK_PS       = 25000;
  localparam int unsigned T_RAS_PS    = 40000;
  localparam int unsigned T_RTP_PS    = 7500;
  localparam int unsigned T_RP_PS     = 12500;
  localparam int unsigned BANKS       = 8;
  localparam int unsigned BANK_W      = 3;
  localparam int unsigned ADDR_W      = 14;
  localparam int unsigned AP_BIT      = 10;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned CNT_W       = 8;
  localparam int unsigned LAT_W       = 3;
  localparam int unsigned RL_MAX      = 16;
  localparam logic [CNT_W-1:0] MIN_PF_GAP = 8'h02;
  localparam logic [CNT_W-1:0] BL8_PF_OFS = 8'h02;
  localparam logic [CNT_W-1:0] WR_EXTRA   = 8'h02;
  localparam logic [CNT_W-1:0] HALF_BL4   = 8'h02;
  localparam logic [CNT_W-1:0] HALF_BL8   = 8'h04;
  localparam logic [CNT_W-1:0] CNT_ONE    = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 8'h00;

  typedef enum logic [2:0] {c_nop, c_act, c_rd, c_wr, c_pre} cmd_type;

  // least time, rounded up to whole clocks, never below one
  function automatic logic [CNT_W-1:0] cyc_up(input int unsigned ps);
    int unsigned c;
    c = (ps + CK_PS - 1) / CK_PS;
    if (c == 0) c = 1;
    return c[CNT_W-1:0];
  endfunction

  function automatic logic [CNT_W-1:0] half_bl(input logic bl8);
    return bl8 ? HALF_BL8 : HALF_BL4;
  endfunction

  function automatic logic [CNT_W-1:0] max2(input logic [CNT_W-1:0] a,
                                            input logic [CNT_W-1:0] b);
    return (a > b) ? a : b;
  endfunction

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] x);
    return (&x) ? x : x + CNT_ONE;
  endfunction
endpackage

// ---- common/rap_link_if.sv ----
// Purpose: command and read-data wires between controller and device
// Assumes: both ends on ref_clk
// Notes:   data and strobe pins carry output enables; bench resolves wires
`timescale 1ns/10ps
`default_nettype none
interface rap_link_if;
  import rap_pkg::*;
  cmd_type                 cmd;
  logic [BANK_W-1:0]       bank;
  logic [ADDR_W-1:0]       addr;
  logic [DATA_W-1:0]       dq;
  logic                    dq_oe;
  logic                    dqs_lo;
  logic                    dqs_hi;
  logic                    dqs_oe;

  modport dev (input cmd, bank, addr,
               output dq, dq_oe, dqs_lo, dqs_hi, dqs_oe);
  modport ctl (output cmd, bank, addr,
               input dq, dq_oe, dqs_lo, dqs_hi, dqs_oe);
endinterface
`default_nettype wire

// ---- rtl/rap_device.sv ----
// Purpose: memory device end: bank state, auto precharge scheduling and
//          read data return
// Assumes: commands sampled on ref_clk; one data word per clock per beat
// Notes:   activate to a bank that is not idle is ignored
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - read with A10 high means auto precharge
// - precharge at AL plus BL/2 when allowed
// - postpone precharge until tRAS and tRTP met
// - tRP counts from the actual precharge start
// - BL4: ACT after AL plus ceil(tRTP+tRP)
// - BL8: ACT after AL+2 plus ceil(tRTP+tRP)
// - round the tRTP+tRP clock count upward
// - precharge never before two clocks after prefetch
// - other banks keep working during auto precharge
// - read other bank after BL/2 clocks
// - write other bank after BL/2+2 clocks
// - precharge/activate other bank after one clock
// - plain read to precharge spacing formula
// - lower strobe with lower byte, upper with upper
// - read data after AL plus CL clocks
// - tRTP counted from last prefetch edge
module rap_device #(
  parameter int unsigned RAS_PS = rap_pkg::T_RAS_PS,
  parameter int unsigned RTP_PS = rap_pkg::T_RTP_PS,
  parameter int unsigned RP_PS  = rap_pkg::T_RP_PS
) (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         nrst,
  // mode settings
  input  wire logic [rap_pkg::LAT_W-1:0]    add_lat,
  input  wire logic [rap_pkg::LAT_W-1:0]    cas_lat,
  input  wire logic                         burst8,
  // status
  output logic      [rap_pkg::BANKS-1:0]    bank_idle,
  // link
  rap_link_if.dev                           link
);
  import rap_pkg::*;

  typedef enum logic [1:0] {b_idle, b_open, b_apwait, b_prech} bank_st_type;

  localparam logic [CNT_W-1:0] RAS_CYC = cyc_up(RAS_PS);
  localparam logic [CNT_W-1:0] RTP_CYC = cyc_up(RTP_PS);
  localparam logic [CNT_W-1:0] RP_CYC  = cyc_up(RP_PS);

  bank_st_type      st_q   [BANKS];
  bank_st_type      st_d   [BANKS];
  logic [CNT_W-1:0] act_q  [BANKS];
  logic [CNT_W-1:0] act_d  [BANKS];
  logic [CNT_W-1:0] rd_q   [BANKS];
  logic [CNT_W-1:0] rd_d   [BANKS];
  logic [CNT_W-1:0] lp_q   [BANKS];
  logic [CNT_W-1:0] lp_d   [BANKS];
  logic [CNT_W-1:0] rp_q   [BANKS];
  logic [CNT_W-1:0] rp_d   [BANKS];

  logic [CNT_W-1:0] al_c;
  logic [CNT_W-1:0] sched_c;
  logic [CNT_W-1:0] pf_c;
  logic             rd_hit;

  assign al_c    = CNT_W'(add_lat);
  assign sched_c = al_c + half_bl(burst8);
  // last prefetch edge: AL for BL4, AL+2 for BL8
  assign pf_c    = al_c + (burst8 ? BL8_PF_OFS : CNT_ZERO);

  always_comb begin
    for (int b = 0; b < BANKS; b++) begin
      logic hit;
      hit      = (link.bank == BANK_W'(b));
      st_d[b]  = st_q[b];
      act_d[b] = sat_inc(act_q[b]);
      rd_d[b]  = sat_inc(rd_q[b]);
      lp_d[b]  = lp_q[b];
      rp_d[b]  = sat_inc(rp_q[b]);
      // each bank runs on its own, so auto precharge overlaps others
      case (st_q[b])
        b_idle: begin
          if (hit && link.cmd == c_act) begin
            st_d[b]  = b_open;
            act_d[b] = CNT_ONE;
          end
        end
        b_open: begin
          if (hit && link.cmd == c_rd) begin
            rd_d[b] = CNT_ONE;
            lp_d[b] = pf_c;
            if (link.addr[AP_BIT]) begin
              st_d[b] = b_apwait;
            end
          end else if (hit && link.cmd == c_pre) begin
            st_d[b] = b_prech;
            rp_d[b] = CNT_ONE;
          end
        end
        b_apwait: begin
          // start at scheduled edge, else first edge where all limits hold
          if (rd_q[b] >= sched_c &&
              act_q[b] >= RAS_CYC &&
              rd_q[b] >= lp_q[b] + max2(RTP_CYC, MIN_PF_GAP))
          begin
            st_d[b] = b_prech;
            rp_d[b] = CNT_ONE;
          end
        end
        b_prech: begin
          if (rp_q[b] >= RP_CYC) begin
            st_d[b] = b_idle;
            // the edge that completes tRP may already carry the activate
            if (hit && link.cmd == c_act) begin
              st_d[b]  = b_open;
              act_d[b] = CNT_ONE;
            end
          end
        end
        default: st_d[b] = b_idle;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int b = 0; b < BANKS; b++) begin
        st_q[b]  <= b_idle;
        act_q[b] <= CNT_ZERO;
        rd_q[b]  <= CNT_ZERO;
        lp_q[b]  <= CNT_ZERO;
        rp_q[b]  <= CNT_ZERO;
      end
    end else begin
      for (int b = 0; b < BANKS; b++) begin
        st_q[b]  <= st_d[b];
        act_q[b] <= act_d[b];
        rd_q[b]  <= rd_d[b];
        lp_q[b]  <= lp_d[b];
        rp_q[b]  <= rp_d[b];
      end
    end
  end

  always_comb begin
    for (int b = 0; b < BANKS; b++) begin
      bank_idle[b] = (st_q[b] == b_idle) ||
                     (st_q[b] == b_prech && rp_q[b] >= RP_CYC);
    end
  end

  // read return: a latency line of flags and addresses, then a burst
  logic [RL_MAX-1:0]  lat_q;
  logic [RL_MAX-1:0]  lat_d;
  logic [ADDR_W-1:0]  la_q  [RL_MAX];
  logic [ADDR_W-1:0]  la_d  [RL_MAX];
  logic [CNT_W-1:0]   beat_q;
  logic [CNT_W-1:0]   beat_d;
  logic [DATA_W-1:0]  dq_q;
  logic [DATA_W-1:0]  dq_d;
  logic               oe_q;
  logic               oe_d;
  logic               slo_q;
  logic               slo_d;
  logic               shi_q;
  logic               shi_d;
  logic [LAT_W:0]     rl_c;
  logic [LAT_W:0]     tap_c;

  assign rd_hit = (link.cmd == c_rd) &&
                  (st_q[link.bank] == b_open);
  assign rl_c   = {1'b0, add_lat} + {1'b0, cas_lat};
  assign tap_c  = (rl_c == '0) ? '0 : rl_c - 1'b1;

  always_comb begin
    lat_d    = {lat_q[RL_MAX-2:0], rd_hit};
    la_d[0]  = link.addr;
    for (int i = 1; i < RL_MAX; i++) begin
      la_d[i] = la_q[i-1];
    end
    beat_d = beat_q;
    dq_d   = dq_q;
    oe_d   = 1'b0;
    slo_d  = 1'b0;
    shi_d  = 1'b0;
    // reads are spaced by at least BL/2, so bursts never overlap
    if (lat_q[tap_c]) begin
      beat_d = CNT_ONE;
      dq_d   = DATA_W'(la_q[tap_c]);
      oe_d   = 1'b1;
    end else if (oe_q && beat_q < half_bl(burst8)) begin
      beat_d = beat_q + CNT_ONE;
      dq_d   = dq_q + DATA_W'(1);
      oe_d   = 1'b1;
      // both strobes start low on the first beat and toggle on each later beat, each framing its own byte lane
      slo_d  = ~slo_q;
      shi_d  = ~shi_q;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lat_q  <= '0;
      beat_q <= CNT_ZERO;
      dq_q   <= '0;
      oe_q   <= 1'b0;
      slo_q  <= 1'b0;
      shi_q  <= 1'b0;
      for (int i = 0; i < RL_MAX; i++) begin
        la_q[i] <= '0;
      end
    end else begin
      lat_q  <= lat_d;
      beat_q <= beat_d;
      dq_q   <= dq_d;
      oe_q   <= oe_d;
      slo_q  <= slo_d;
      shi_q  <= shi_d;
      for (int i = 0; i < RL_MAX; i++) begin
        la_q[i] <= la_d[i];
      end
    end
  end

  assign link.dq     = dq_q;
  assign link.dq_oe  = oe_q;
  assign link.dqs_lo = slo_q;
  assign link.dqs_hi = shi_q;
  assign link.dqs_oe = oe_q;
endmodule // rap_device
`default_nettype wire

// ---- rtl/rap_controller.sv ----
// Purpose: controller end: issues commands with the spacing the device needs
// Assumes: user holds a request until req_ready; one command per clock
// Notes:   does not track tRCD or tRAS before an explicit precharge
`timescale 1ns/10ps
`default_nettype none
module rap_controller #(
  parameter int unsigned RTP_PS = rap_pkg::T_RTP_PS,
  parameter int unsigned RP_PS  = rap_pkg::T_RP_PS
) (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         nrst,
  // mode settings
  input  wire logic [rap_pkg::LAT_W-1:0]    add_lat,
  input  wire logic                         burst8,
  // request
  input  wire logic                         req_valid,
  input  wire rap_pkg::cmd_type             req_cmd,
  input  wire logic [rap_pkg::BANK_W-1:0]   req_bank,
  input  wire logic [rap_pkg::ADDR_W-1:0]   req_addr,
  output logic                              req_ready,
  // read data
  output logic [rap_pkg::DATA_W-1:0]        rdata,
  output logic                              rdata_valid,
  // link
  rap_link_if.ctl                           link
);
  import rap_pkg::*;

  localparam logic [CNT_W-1:0] RTP_CYC = cyc_up(RTP_PS);
  // whole-term rounding, not per-term
  localparam logic [CNT_W-1:0] ACT_CYC = cyc_up(RTP_PS + RP_PS);
  localparam logic [CNT_W-1:0] RP_CYC  = cyc_up(RP_PS);

  logic [CNT_W-1:0] actw_q [BANKS];
  logic [CNT_W-1:0] actw_d [BANKS];
  logic [CNT_W-1:0] prew_q [BANKS];
  logic [CNT_W-1:0] prew_d [BANKS];
  logic [CNT_W-1:0] rdg_q;
  logic [CNT_W-1:0] rdg_d;
  logic [CNT_W-1:0] wrg_q;
  logic [CNT_W-1:0] wrg_d;
  cmd_type          cmd_q;
  cmd_type          cmd_d;
  logic [BANK_W-1:0] bank_q;
  logic [BANK_W-1:0] bank_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [DATA_W-1:0] rdata_q;
  logic              rvalid_q;
  logic              fire;
  logic [CNT_W-1:0]  al_c;
  logic [CNT_W-1:0]  ap_act_c;
  logic [CNT_W-1:0]  rd_pre_c;

  function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] x);
    return (x == CNT_ZERO) ? x : x - CNT_ONE;
  endfunction

  assign al_c     = CNT_W'(add_lat);
  // wait figures are loaded as spacing minus one
  // a short tRTP cannot pull the activate ahead of the two-clock floor
  assign ap_act_c = al_c + (burst8 ? BL8_PF_OFS : CNT_ZERO)
                  + max2(ACT_CYC, MIN_PF_GAP + RP_CYC)
                  - CNT_ONE;
  assign rd_pre_c = al_c + half_bl(burst8) - MIN_PF_GAP
                  + max2(RTP_CYC, MIN_PF_GAP) - CNT_ONE;

  always_comb begin
    case (req_cmd)
      c_act:   req_ready = (actw_q[req_bank] == CNT_ZERO);
      c_pre:   req_ready = (prew_q[req_bank] == CNT_ZERO);
      c_rd:    req_ready = (rdg_q == CNT_ZERO);
      c_wr:    req_ready = (wrg_q == CNT_ZERO);
      default: req_ready = 1'b1;
    endcase
  end
  assign fire = req_valid && req_ready;

  always_comb begin
    rdg_d  = dec(rdg_q);
    wrg_d  = dec(wrg_q);
    cmd_d  = c_nop;
    bank_d = bank_q;
    addr_d = addr_q;
    for (int b = 0; b < BANKS; b++) begin
      actw_d[b] = dec(actw_q[b]);
      prew_d[b] = dec(prew_q[b]);
    end
    if (fire) begin
      cmd_d  = req_cmd;
      bank_d = req_bank;
      addr_d = req_addr;
      if (req_cmd == c_rd) begin
        // other banks: pre/act one clock on, no extra wait
        rdg_d = half_bl(burst8) - CNT_ONE;
        wrg_d = half_bl(burst8) + WR_EXTRA - CNT_ONE;
        if (req_addr[AP_BIT]) begin
          actw_d[req_bank] = ap_act_c;
        end else begin
          prew_d[req_bank] = rd_pre_c;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdg_q    <= CNT_ZERO;
      wrg_q    <= CNT_ZERO;
      cmd_q    <= c_nop;
      bank_q   <= '0;
      addr_q   <= '0;
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
      for (int b = 0; b < BANKS; b++) begin
        actw_q[b] <= CNT_ZERO;
        prew_q[b] <= CNT_ZERO;
      end
    end else begin
      rdg_q    <= rdg_d;
      wrg_q    <= wrg_d;
      cmd_q    <= cmd_d;
      bank_q   <= bank_d;
      addr_q   <= addr_d;
      rdata_q  <= link.dq_oe ? link.dq : rdata_q;
      rvalid_q <= link.dq_oe;
      for (int b = 0; b < BANKS; b++) begin
        actw_q[b] <= actw_d[b];
        prew_q[b] <= prew_d[b];
      end
    end
  end

  assign link.cmd    = cmd_q;
  assign link.bank   = bank_q;
  assign link.addr   = addr_q;
  assign rdata       = rdata_q;
  assign rdata_valid = rvalid_q;
endmodule // rap_controller
`default_nettype wire

// ---- sim/rap_asserts.sv ----
// Purpose: timing checks on the link between controller and device ends
// Assumes: one clock domain; mode inputs change only while all banks idle
// Notes:   ages count edges since the last read of each kind and, per bank, since the last activate
`timescale 1ns/10ps
`default_nettype none
module rap_asserts #(
  parameter int unsigned RTP_PS = rap_pkg::T_RTP_PS,
  parameter int unsigned RP_PS  = rap_pkg::T_RP_PS
) (
  // clock and reset
  input wire logic                       ref_clk,
  input wire logic                       nrst,
  // mode and status
  input wire logic [rap_pkg::LAT_W-1:0]  add_lat,
  input wire logic [rap_pkg::LAT_W-1:0]  cas_lat,
  input wire logic                       burst8,
  input wire logic [rap_pkg::BANKS-1:0]  bank_idle,
  // link
  input wire rap_pkg::cmd_type           cmd,
  input wire logic [rap_pkg::BANK_W-1:0] bank,
  input wire logic [rap_pkg::ADDR_W-1:0] addr,
  input wire logic                       dq_oe,
  input wire logic                       dqs_lo,
  input wire logic                       dqs_hi,
  input wire logic                       dqs_oe
);
  import rap_pkg::*;
  localparam int unsigned RTPC = (RTP_PS + CK_PS - 1) / CK_PS;
  localparam int unsigned RPC  = (RP_PS + CK_PS - 1) / CK_PS;
  localparam int unsigned APC  = (RTP_PS + RP_PS + CK_PS - 1) / CK_PS;
  localparam int unsigned GAP  = (RTPC > 2) ? RTPC : 2;
  localparam int unsigned RASC = (T_RAS_PS + CK_PS - 1) / CK_PS;

  int unsigned       hb, ofs, need_act, need_pre, idle_min;
  logic [CNT_W-1:0]  rd_age_q, rd_age_d, ap_age_q, ap_age_d;
  logic [CNT_W-1:0]  pr_age_q, pr_age_d, run_q, run_d;
  logic [BANK_W-1:0] ap_bank_q, ap_bank_d, pr_bank_q, pr_bank_d;
  logic [RL_MAX-1:0] pipe_q, pipe_d;
  logic              rd_ap, rd_pl;
  logic [CNT_W-1:0]  act_age_q [BANKS], act_age_d [BANKS];

  // saturate so an old read never looks recent again
  function automatic logic [CNT_W-1:0] sat_up(input logic [CNT_W-1:0] x);
    return (&x) ? x : x + 8'h01;
  endfunction

  always_comb begin
    hb = burst8 ? 4 : 2;
    ofs = burst8 ? 2 : 0;
    need_act = add_lat + ofs + APC;
    need_pre = add_lat + hb - 2 + GAP;
    idle_min = ((add_lat + ofs + GAP > hb) ? add_lat + ofs + GAP : hb);
    idle_min = idle_min + RPC;
    rd_ap = (cmd == c_rd) && addr[AP_BIT];
    rd_pl = (cmd == c_rd) && !addr[AP_BIT];
    rd_age_d = (cmd == c_rd) ? 8'h01 : sat_up(rd_age_q);
    ap_age_d = rd_ap ? 8'h01 : sat_up(ap_age_q);
    pr_age_d = rd_pl ? 8'h01 : sat_up(pr_age_q);
    ap_bank_d = rd_ap ? bank : ap_bank_q;
    pr_bank_d = rd_pl ? bank : pr_bank_q;
    run_d = dq_oe ? sat_up(run_q) : 8'h00;
    pipe_d = {pipe_q[RL_MAX-2:0], cmd == c_rd};
    for (int b = 0; b < BANKS; b++) begin
      act_age_d[b] = (cmd == c_act && bank == BANK_W'(b)) ? 8'h01
                                                         : sat_up(act_age_q[b]);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_age_q <= 8'hff;
      ap_age_q <= 8'hff;
      pr_age_q <= 8'hff;
      ap_bank_q <= '0;
      pr_bank_q <= '0;
      run_q <= 8'h00;
      pipe_q <= '0;
      for (int b = 0; b < BANKS; b++) begin
        act_age_q[b] <= 8'hff;
      end
    end else begin
      rd_age_q <= rd_age_d;
      ap_age_q <= ap_age_d;
      pr_age_q <= pr_age_d;
      ap_bank_q <= ap_bank_d;
      pr_bank_q <= pr_bank_d;
      run_q <= run_d;
      pipe_q <= pipe_d;
      for (int b = 0; b < BANKS; b++) begin
        act_age_q[b] <= act_age_d[b];
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  chk_read_latency: assert property (
    pipe_q[int'(add_lat) + int'(cas_lat)] |-> dq_oe && !dqs_lo && !dqs_hi)
    else $error("read data not driven at read latency");
  chk_oe_pair: assert property (dq_oe == dqs_oe)
    else $error("strobe enable differs from data enable");
  chk_strobe_lanes: assert property (
    dq_oe && $past(dq_oe) |-> dqs_lo != $past(dqs_lo) && dqs_hi == dqs_lo)
    else $error("byte strobes not toggling together");
  chk_burst_whole: assert property ($fell(dq_oe) |-> run_q % hb == 0)
    else $error("read burst cut short");
  chk_read_gap: assert property (cmd == c_rd |-> rd_age_q >= hb)
    else $error("reads closer than half burst");
  chk_write_gap: assert property (cmd == c_wr |-> rd_age_q >= hb + 2)
    else $error("write too soon after read");
  chk_act_gap: assert property (
    cmd == c_act && bank == ap_bank_q |-> ap_age_q >= need_act)
    else $error("activate too soon after auto precharge read");
  chk_pre_gap: assert property (
    cmd == c_pre && bank == pr_bank_q |-> pr_age_q >= need_pre)
    else $error("precharge too soon after read");
  chk_idle_late: assert property (
    $rose(bank_idle[ap_bank_q]) |-> ap_age_q >= idle_min)
    else $error("bank idle before precharge period ran");
  chk_ap_closes: assert property (
    ap_age_q == idle_min && act_age_q[ap_bank_q] >= RASC + RPC
    |-> bank_idle[ap_bank_q])
    else $error("auto precharge bank not idle in time");
  cover property (cmd == c_act && bank == ap_bank_q && ap_age_q < 8'h10);
endmodule // rap_asserts
`default_nettype wire

// ---- sim/test_read_auto_precharge_timing.sv ----
// Purpose: drives the controller user side against the device end
// Assumes: 40 MHz ref_clk; inputs change 1 ns after the rising edge
// Notes:   modes change only with all banks idle
`timescale 1ns/10ps
`default_nettype none
module test_read_auto_precharge_timing;
  import rap_pkg::*;
  logic              ref_clk, nrst, burst8, req_valid, req_ready;
  logic [LAT_W-1:0]  add_lat, cas_lat;
  logic [BANKS-1:0]  bank_idle;
  cmd_type           req_cmd;
  logic [BANK_W-1:0] req_bank, b0, b1;
  logic [ADDR_W-1:0] req_addr, a0, a1;
  logic [DATA_W-1:0] rdata, exp_q[$];
  logic              rdata_valid;
  logic [15:0]       seed;
  int                fail_count, checks, hb;

  rap_link_if link();
  rap_device rap_device_i (.ref_clk(ref_clk), .nrst(nrst),
    .add_lat(add_lat), .cas_lat(cas_lat), .burst8(burst8),
    .bank_idle(bank_idle), .link(link));
  rap_controller rap_controller_i (.ref_clk(ref_clk), .nrst(nrst),
    .add_lat(add_lat), .burst8(burst8), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
    .req_ready(req_ready), .rdata(rdata), .rdata_valid(rdata_valid),
    .link(link));
  rap_asserts rap_asserts_i (.ref_clk(ref_clk), .nrst(nrst),
    .add_lat(add_lat), .cas_lat(cas_lat), .burst8(burst8),
    .bank_idle(bank_idle), .cmd(link.cmd), .bank(link.bank),
    .addr(link.addr), .dq_oe(link.dq_oe), .dqs_lo(link.dqs_lo),
    .dqs_hi(link.dqs_hi), .dqs_oe(link.dqs_oe));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
  endfunction

  task automatic check(input string what, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // holds the request until taken; leaves valid up for the next call
  task automatic issue(input cmd_type c, input logic [BANK_W-1:0] b,
                       input logic [ADDR_W-1:0] a);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_cmd = c;
    req_bank = b;
    req_addr = a;
    // ready is combinational: look at it mid-cycle, where it has settled
    @(negedge ref_clk);
    while (req_ready !== 1'b1) begin
      n++;
      if (n > 200) begin
        fail_count++;
        test_done();
      end
      @(negedge ref_clk);
    end
    @(posedge ref_clk);
    if (c == c_rd)
      for (int k = 0; k < hb; k++) exp_q.push_back(16'(a) + 16'(k));
    #1;
  endtask

  always @(negedge ref_clk) begin
    if (rdata_valid === 1'b1)
      check("rdata", rdata, exp_q.size() ? exp_q.pop_front() : ~rdata);
  end

  initial begin
    int n;
    nrst = 1'b0;
    req_valid = 1'b0;
    req_cmd = c_nop;
    req_bank = '0;
    req_addr = '0;
    add_lat = 3'h0;
    cas_lat = 3'h3;
    burst8 = 1'b0;
    fail_count = 0;
    checks = 0;
    seed = 16'h4885;
    repeat (3) @(posedge ref_clk);
    #1 nrst = 1'b1;
    for (int m = 0; m < 8; m++) begin
      burst8 = m[0];
      add_lat = 3'(m >> 1);
      cas_lat = m[2] ? 3'h5 : 3'h3;
      hb = burst8 ? 4 : 2;
      seed = lfsr_next(seed);
      b0 = seed[2:0];
      b1 = b0 ^ 3'h5;
      seed = lfsr_next(seed);
      a0 = seed[13:0] & 14'h3bff;
      seed = lfsr_next(seed);
      a1 = seed[13:0] | 14'h0400;
      if (m == 0) begin
        a0 = 14'h3bff; // carry across the low bits
        a1 = 14'h0400;
      end
      issue(c_act, b0, 14'h0000);
      issue(c_act, b1, 14'h0000);
      issue(c_rd, b0, a0);
      issue(c_rd, b1, a1);
      issue(c_wr, b0, a0);
      issue(c_act, b1, 14'h0000);
      check("plain read bank open", 16'(bank_idle[b0]), 16'h0000);
      issue(c_pre, b0, 14'h0000);
      check("activate after auto precharge", 16'(bank_idle[b1]), 16'h0000);
      issue(c_pre, b1, 14'h0000);
      req_valid = 1'b0;
      n = 0;
      while (bank_idle !== '1) begin
        n++;
        if (n > 200) begin
          fail_count++;
          test_done();
        end
        @(posedge ref_clk);
      end
      // the last burst may still be on its way back
      repeat (20) @(posedge ref_clk);
      #1;
      check("banks idle", 16'(bank_idle), 16'h00ff);
      check("words left", 16'(exp_q.size()), 16'h0000);
    end
    test_done();
  end
endmodule // test_read_auto_precharge_timing
`default_nettype wire
